/* core/dvo_defines.vh */
// Purpose: Shared constants for the divider square-wave output unit.
// Assumes: Included by bare name from the top-level design file and from the checker and bench.
// Notes:   Definitions only; no logic lives here.
`ifndef DVO_DEFINES_VH
`define DVO_DEFINES_VH

// Register byte addresses on the 8-bit AXI4-Lite address.
`define ADDR_W             8
`define DIV_OUT_CTRL_ADDR  8'h38
`define SRC_CTRL_ADDR      8'h3C
// Word indices of the same registers, as seen on address bits 7..2.
`define DIV_OUT_CTRL_IDX   6'h0E
`define SRC_CTRL_IDX       6'h0F
`define WORD_LSB           2

// Field positions and widths of the control registers.
`define OUT_EN_BIT         2
`define FSEL_HI            1
`define FSEL_LO            0
`define SRC_SEL_BIT        0
`define PIN_STATE_BIT      1
`define UPPER_ZERO_W       5
`define SRC_ZERO_W         30
`define REG_RESET_BIT      1'h0
`define FSEL_RESET         2'h0

// Operating modes presented by the system power controller.
`define MODE_W             3
`define MODE_NORMAL        3'h0
`define MODE_IDLE          3'h1
`define MODE_SLOW          3'h2
`define MODE_LIGHT_SLEEP   3'h3
`define MODE_STOP          3'h4
`define MODE_DEEP_IDLE     3'h5
`define MODE_DEEP_SLEEP    3'h6

// Divider chains: widths and output tap positions.
`define GEAR_CHAIN_W       12
`define LF_CHAIN_W         5
`define GEAR_TAP_SEL0      11
`define GEAR_TAP_SEL1      10
`define GEAR_TAP_SEL2      9
`define GEAR_TAP_SEL3      8
`define LF_TAP_SEL0        4
`define LF_TAP_SEL1        3
`define LF_TAP_SEL2        2

// Frequency select codes.
`define FSEL_CODE0         2'h0
`define FSEL_CODE1         2'h1
`define FSEL_CODE2         2'h2
`define FSEL_CODE3         2'h3

// AXI4-Lite response codes and data width.
`define DATA_W             32
`define RESP_OKAY          2'h0
`define RESP_SLVERR        2'h2

`endif

/* core/divider_chain.v */
// Purpose: Free-running binary divider chain that advances on a step pulse.
// Assumes: Step is a one-cycle pulse synchronous to clk.
// Notes:   Never gated by the output enable, so taps keep running at all times.
`timescale 1ns/1ps
module divider_chain #(
	parameter WIDTH = 12
) (
	// Clock and reset.
	input  wire             clk,
	input  wire             srst,
	// Advance strobe.
	input  wire             step,
	// Chain state.
	output reg  [WIDTH-1:0] count_r
);

	// Count up by one on every step, wrapping at the top.
	always @(posedge clk) begin
		if (srst) begin
			count_r <= {WIDTH{1'b0}};
		end else if (step) begin
			count_r <= count_r + {{(WIDTH-1){1'b0}}, 1'b1};
		end
	end

endmodule

/* core/lf_clock_sync.v */
// Purpose: Resynchronises the low-frequency clock and marks its rising edges.
// Assumes: The low-frequency clock is slower than half of clk.
// Notes:   The first stage feeds only the second, so the edge detector sees a clean level.
`timescale 1ns/1ps
module lf_clock_sync (
	// Clock and reset.
	input  wire clk,
	input  wire srst,
	// Raw low-frequency clock level.
	input  wire lf_level,
	// One-cycle pulse per rising edge.
	output wire lf_rise
);

	reg meta_r;
	reg sync_r;
	reg prev_r;

	// Two-stage synchroniser followed by an edge history stage.
	always @(posedge clk) begin
		if (srst) begin
			meta_r <= 1'b0;
			sync_r <= 1'b0;
			prev_r <= 1'b0;
		end else begin
			meta_r <= lf_level;
			sync_r <= meta_r;
			prev_r <= sync_r;
		end
	end

	// Rising edge of the synchronised level.
	assign lf_rise = sync_r & ~prev_r;

endmodule

/* core/divider_square_wave_output.v */
// Purpose: Divider square-wave output with an AXI4-Lite register slave.
// Assumes: core_clk is the gear clock; power_mode is synchronous to core_clk.
// Notes:   The pin is active low and idles high whenever the output is off.
//
// Behaviour
// [RULE1] Writing enable one starts wave; resets zero.
// [RULE2] Pin carries selected wave, driven active low.
// [RULE3] Gear source codes divide by 4096..512.
// [RULE4] Low-frequency source codes divide 32..8; 11 reserved.
// [RULE5] Stop or deep modes clear enable, pin high.
// [RULE6] Enable cleared stops wave, pin held high.
// [RULE7] Control register bits 7..3 read zero.
// [RULE8] Divider chains run regardless of enable.
// [RULE9] Forced disable truncates the final period.
// [RULE10] Low-frequency source resynchronised, period may jitter.
// [RULE11] Mode switch between sources may disturb frequency.
// [RULE12] Output duty cycle is about half.
// [RULE13] Select change while running may glitch once.
//
// The implementer's own choice: the AXI4-Lite slave port.
`timescale 1ns/1ps
`include "dvo_defines.vh"
module divider_square_wave_output (
	// Clock and reset.
	input  wire                 core_clk,
	input  wire                 srst,

	// Low-frequency clock and operating mode.
	input  wire                 low_frequency_clock,
	input  wire [`MODE_W-1:0]   power_mode,

	// Buzzer pin, active low.
	output reg                  buzzer_pulse_pin_n,

	// AXI4-Lite write address channel.
	input  wire                 s_axi_awvalid,
	output wire                 s_axi_awready,
	input  wire [`ADDR_W-1:0]   s_axi_awaddr,
	input  wire [2:0]           s_axi_awprot,

	// AXI4-Lite write data channel.
	input  wire                 s_axi_wvalid,
	output wire                 s_axi_wready,
	input  wire [`DATA_W-1:0]   s_axi_wdata,
	input  wire [3:0]           s_axi_wstrb,

	// AXI4-Lite write response channel.
	output reg                  s_axi_bvalid,
	input  wire                 s_axi_bready,
	output reg  [1:0]           s_axi_bresp,

	// AXI4-Lite read address channel.
	input  wire                 s_axi_arvalid,
	output wire                 s_axi_arready,
	input  wire [`ADDR_W-1:0]   s_axi_araddr,
	input  wire [2:0]           s_axi_arprot,

	// AXI4-Lite read data channel.
	output reg                  s_axi_rvalid,
	input  wire                 s_axi_rready,
	output reg  [`DATA_W-1:0]   s_axi_rdata,
	output reg  [1:0]           s_axi_rresp
);

	// Register state.
	reg                         output_enable_bit_r;
	reg  [1:0]                  frequency_select_r;
	reg                         divider_source_select_r;

	// Write channel holding registers.
	reg                         aw_held_r;
	reg  [`ADDR_W-1:0]          aw_addr_r;
	reg                         w_held_r;
	reg  [`DATA_W-1:0]          w_data_r;
	reg  [3:0]                  w_strb_r;

	// Previous mode, used to spot entry into a deep mode.
	reg  [`MODE_W-1:0]          mode_prev_r;

	// Divider chain state and tap selection.
	wire [`GEAR_CHAIN_W-1:0]    gear_count;
	wire [`LF_CHAIN_W-1:0]      lf_count;
	wire                        lf_rise;
	reg                         tap_level;
	reg                         tap_valid;

	// Decoded mode conditions.
	wire                        deep_mode;
	wire                        entering_deep;
	wire                        lf_mode;
	wire                        use_lf;

	// Write commit decode.
	wire                        wr_commit;
	wire                        wr_ctrl_hit;
	wire                        wr_src_hit;
	wire                        wr_lane0;

	// Read decode.
	wire                        rd_take;
	reg  [`DATA_W-1:0]          rd_word;
	reg                         rd_hit;

	// Unused protection fields are accepted and ignored.
	wire [5:0]                  prot_unused;
	assign prot_unused = {s_axi_awprot, s_axi_arprot};

	// ------------------------------------------------------------------
	// Divider chains.
	// ------------------------------------------------------------------

	// The gear chain steps every clock, so bit n toggles every 2^n cycles.
	divider_chain #(
		.WIDTH (`GEAR_CHAIN_W)
	) u_gear_chain (
		.clk     (core_clk),
		.srst    (srst),
		.step    (1'b1), // RULE8
		.count_r (gear_count)
	);

	// The low-frequency clock is brought into the gear domain first.
	// Its edges land on gear-clock edges, so periods may wander by a cycle.
	lf_clock_sync u_lf_sync (
		.clk      (core_clk),
		.srst     (srst),
		.lf_level (low_frequency_clock),
		.lf_rise  (lf_rise) // RULE10
	);

	// The low-frequency chain advances once per low-frequency period.
	divider_chain #(
		.WIDTH (`LF_CHAIN_W)
	) u_lf_chain (
		.clk     (core_clk),
		.srst    (srst),
		.step    (lf_rise), // RULE8
		.count_r (lf_count)
	);

	// ------------------------------------------------------------------
	// Mode decode.
	// ------------------------------------------------------------------

	// Stop, deep idle and deep sleep all shut the output down.
	assign deep_mode = (power_mode == `MODE_STOP) ||
	                   (power_mode == `MODE_DEEP_IDLE) ||
	                   (power_mode == `MODE_DEEP_SLEEP);

	// Entry is the first cycle spent in a deep mode after any other mode.
	assign entering_deep = deep_mode &&
	                       (mode_prev_r != `MODE_STOP) &&
	                       (mode_prev_r != `MODE_DEEP_IDLE) &&
	                       (mode_prev_r != `MODE_DEEP_SLEEP);

	// Slow and light sleep have no gear clock, so they force the slow source.
	assign lf_mode = (power_mode == `MODE_SLOW) ||
	                 (power_mode == `MODE_LIGHT_SLEEP);

	// Source choice switches at once; a mode change may bend one period.
	assign use_lf = divider_source_select_r | lf_mode; // RULE11

	// Track the mode of the previous cycle.
	always @(posedge core_clk) begin
		if (srst) begin
			mode_prev_r <= `MODE_NORMAL;
		end else begin
			mode_prev_r <= power_mode;
		end
	end

	// ------------------------------------------------------------------
	// Tap selection.
	// ------------------------------------------------------------------

	// A single chain bit is a square wave of exactly half duty.
	// The tap moves immediately when the select changes, which can give
	// one short or long period; software should change it while disabled.
	always @* begin
		tap_level = 1'b0;
		tap_valid = 1'b1;
		if (use_lf) begin
			case (frequency_select_r) // RULE4
				`FSEL_CODE0: begin
					tap_level = lf_count[`LF_TAP_SEL0];
				end
				`FSEL_CODE1: begin
					tap_level = lf_count[`LF_TAP_SEL1];
				end
				`FSEL_CODE2: begin
					tap_level = lf_count[`LF_TAP_SEL2];
				end
				default: begin
					tap_valid = 1'b0; // Reserved code keeps the pin idle.
				end
			endcase
		end else begin
			case (frequency_select_r) // RULE3
				`FSEL_CODE0: begin
					tap_level = gear_count[`GEAR_TAP_SEL0];
				end
				`FSEL_CODE1: begin
					tap_level = gear_count[`GEAR_TAP_SEL1];
				end
				`FSEL_CODE2: begin
					tap_level = gear_count[`GEAR_TAP_SEL2];
				end
				default: begin
					tap_level = gear_count[`GEAR_TAP_SEL3];
				end
			endcase
		end
	end

	// ------------------------------------------------------------------
	// Pin driver.
	// ------------------------------------------------------------------

	// The pin is low while the tap is high and the output is on.
	// Dropping the enable drives it high on the next edge, cutting the
	// period short; the pin never waits for the wave to finish.
	always @(posedge core_clk) begin
		if (srst) begin
			buzzer_pulse_pin_n <= 1'b1;
		end else if (!output_enable_bit_r || deep_mode) begin
			buzzer_pulse_pin_n <= 1'b1; // RULE6 RULE9
		end else begin
			buzzer_pulse_pin_n <= ~(tap_level & tap_valid); // RULE2 RULE12
		end
	end

	// ------------------------------------------------------------------
	// AXI4-Lite write path.
	// ------------------------------------------------------------------

	// Each channel is taken once and held until the pair is complete.
	// No new request is taken while a response waits for bready.
	assign s_axi_awready = ~aw_held_r & ~s_axi_bvalid;
	assign s_axi_wready  = ~w_held_r & ~s_axi_bvalid;

	// A write commits once both halves are held.
	assign wr_commit   = aw_held_r & w_held_r & ~s_axi_bvalid;
	assign wr_ctrl_hit = (aw_addr_r[`ADDR_W-1:`WORD_LSB] ==
	                      `DIV_OUT_CTRL_IDX);
	assign wr_src_hit  = (aw_addr_r[`ADDR_W-1:`WORD_LSB] ==
	                      `SRC_CTRL_IDX);
	assign wr_lane0    = w_strb_r[0];

	// Hold the write address until the data arrives.
	always @(posedge core_clk) begin
		if (srst) begin
			aw_held_r <= 1'b0;
			aw_addr_r <= {`ADDR_W{1'b0}};
		end else if (s_axi_awvalid && s_axi_awready) begin
			aw_held_r <= 1'b1;
			aw_addr_r <= s_axi_awaddr;
		end else if (wr_commit) begin
			aw_held_r <= 1'b0;
		end
	end

	// Hold the write data until the address arrives.
	always @(posedge core_clk) begin
		if (srst) begin
			w_held_r <= 1'b0;
			w_data_r <= {`DATA_W{1'b0}};
			w_strb_r <= 4'h0;
		end else if (s_axi_wvalid && s_axi_wready) begin
			w_held_r <= 1'b1;
			w_data_r <= s_axi_wdata;
			w_strb_r <= s_axi_wstrb;
		end else if (wr_commit) begin
			w_held_r <= 1'b0;
		end
	end

	// Write response: unmapped addresses answer with a slave error.
	always @(posedge core_clk) begin
		if (srst) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= `RESP_OKAY;
		end else if (wr_commit) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp  <= (wr_ctrl_hit || wr_src_hit) ? `RESP_OKAY : `RESP_SLVERR;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// ------------------------------------------------------------------
	// Control registers.
	// ------------------------------------------------------------------

	// Deep-mode entry beats a software write in the same cycle, and a
	// write cannot turn the output on while a deep mode lasts.
	// The select field is left alone by the forced clear.
	always @(posedge core_clk) begin
		if (srst) begin
			output_enable_bit_r <= `REG_RESET_BIT; // RULE1
			frequency_select_r  <= `FSEL_RESET;
		end else begin
			if (wr_commit && wr_ctrl_hit && wr_lane0) begin
				frequency_select_r <= w_data_r[`FSEL_HI:`FSEL_LO]; // RULE13
			end
			if (entering_deep || deep_mode) begin
				output_enable_bit_r <= 1'b0; // RULE5
			end else if (wr_commit && wr_ctrl_hit && wr_lane0) begin
				output_enable_bit_r <= w_data_r[`OUT_EN_BIT]; // RULE1 RULE6
			end
		end
	end

	// Divider source select, kept apart from the output control.
	always @(posedge core_clk) begin
		if (srst) begin
			divider_source_select_r <= `REG_RESET_BIT;
		end else if (wr_commit && wr_src_hit && wr_lane0) begin
			divider_source_select_r <= w_data_r[`SRC_SEL_BIT];
		end
	end

	// ------------------------------------------------------------------
	// AXI4-Lite read path.
	// ------------------------------------------------------------------

	// One read at a time; the address is taken only while no data waits.
	assign s_axi_arready = ~s_axi_rvalid;
	assign rd_take       = s_axi_arvalid & s_axi_arready;

	// Read multiplexer; upper bits of every register read as zero.
	always @* begin
		rd_word = {`DATA_W{1'b0}};
		rd_hit  = 1'b1;
		case (s_axi_araddr[`ADDR_W-1:`WORD_LSB])
			`DIV_OUT_CTRL_IDX: begin
				rd_word[`OUT_EN_BIT]       = output_enable_bit_r;
				rd_word[`FSEL_HI:`FSEL_LO] = frequency_select_r; // RULE7
			end
			`SRC_CTRL_IDX: begin
				rd_word[`SRC_SEL_BIT]   = divider_source_select_r;
				rd_word[`PIN_STATE_BIT] = buzzer_pulse_pin_n;
			end
			default: begin
				rd_hit = 1'b0;
			end
		endcase
	end

	// Registered read data, held until rready.
	always @(posedge core_clk) begin
		if (srst) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= {`DATA_W{1'b0}};
			s_axi_rresp  <= `RESP_OKAY;
		end else if (rd_take) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata  <= rd_word;
			s_axi_rresp  <= rd_hit ? `RESP_OKAY : `RESP_SLVERR;
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

endmodule

/* sim/square_wave_checker.sv */
// Purpose: Port-level checks for the divider square-wave output.
// Assumes: Sees only the top-level ports; one clock domain.
// Notes:   Bound to the design at the foot of this file.
`timescale 1ns/1ps
`include "dvo_defines.vh"
module square_wave_checker (
	// Clock, reset and mode.
	input wire                 core_clk,
	input wire                 srst,
	input wire [`MODE_W-1:0]   power_mode,
	// Buzzer pin.
	input wire                 buzzer_pulse_pin_n,
	// Register bus.
	input wire                 s_axi_awvalid,
	input wire                 s_axi_awready,
	input wire                 s_axi_wvalid,
	input wire                 s_axi_wready,
	input wire                 s_axi_bvalid,
	input wire                 s_axi_bready,
	input wire [1:0]           s_axi_bresp,
	input wire                 s_axi_arvalid,
	input wire                 s_axi_arready,
	input wire [`ADDR_W-1:0]   s_axi_araddr,
	input wire                 s_axi_rvalid,
	input wire                 s_axi_rready,
	input wire [`DATA_W-1:0]   s_axi_rdata,
	input wire [1:0]           s_axi_rresp
);
	reg  [`ADDR_W-1:0] rd_addr_r;
	reg  [12:0]        low_run_r;
	wire               deep;

	// Stop and both deep modes share the upper codes.
	assign deep = power_mode >= `MODE_STOP;

	// Keep the read address, since the answer arrives after it is dropped.
	always @(posedge core_clk) begin
		if (s_axi_arvalid && s_axi_arready) begin
			rd_addr_r <= s_axi_araddr;
		end
	end

	// Length of the current low phase; saturates so a stuck pin cannot wrap it.
	always @(posedge core_clk) begin
		if (srst || buzzer_pulse_pin_n) begin
			low_run_r <= 13'h0000;
		end else if (!low_run_r[12]) begin
			low_run_r <= low_run_r + 13'h0001;
		end
	end

	default clocking @(posedge core_clk); endclocking
	default disable iff (srst);

	a_reset_pin_high: assert property (disable iff (1'b0)
		srst |=> buzzer_pulse_pin_n) else $error("pin not high after reset");
	a_deep_pin_high: assert property (
		deep && $past(deep) |-> buzzer_pulse_pin_n) else $error("pin low in deep mode");
	a_upper_zero: assert property (
		s_axi_rvalid && rd_addr_r == `DIV_OUT_CTRL_ADDR |-> s_axi_rdata[31:3] == 29'h0)
		else $error("control upper bits not zero");
	a_bad_addr: assert property (
		s_axi_rvalid && rd_addr_r != `DIV_OUT_CTRL_ADDR && rd_addr_r != `SRC_CTRL_ADDR
		|-> s_axi_rresp == `RESP_SLVERR && s_axi_rdata == 32'h0) else $error("bad read answer");
	a_write_answer: assert property (
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
		else $error("write answer late");
	a_read_answer: assert property (
		s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("read answer late");
	a_b_stands: assert property (
		s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write answer dropped");
	a_r_stands: assert property (
		s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read answer dropped");
	a_low_half: assert property (
		low_run_r <= 13'h0800) else $error("low phase longer than half the slowest period");

	c_pin_fall: cover property ($fell(buzzer_pulse_pin_n));
	c_deep: cover property (deep ##1 deep);
	c_slverr: cover property (s_axi_bvalid && s_axi_bresp == `RESP_SLVERR);
endmodule

bind divider_square_wave_output square_wave_checker u_chk (
	.core_clk(core_clk), .srst(srst), .power_mode(power_mode),
	.buzzer_pulse_pin_n(buzzer_pulse_pin_n),
	.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
	.s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
	.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp),
	.s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
	.s_axi_araddr(s_axi_araddr), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
	.s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp)
);

/* sim/buzzer_load.sv */
// Purpose: Buzzer load model that times the pin, plus the slow oscillator.
// Assumes: Pin is sampled on core_clk rising edges.
// Notes:   The slow clock runs free and is not phase-locked to core_clk.
`timescale 1ns/1ps
module buzzer_load #(
	parameter int LF_HALF_NS = 613
) (
	input  wire  core_clk,
	input  wire  buzzer_pulse_pin_n,
	output logic low_frequency_clock,
	output int   fall_cnt,
	output int   period,
	output int   low_len
);
	int   run_r;
	int   low_r;
	logic prev_r;

	initial low_frequency_clock = 1'b0;

	// An odd half period keeps the two clocks drifting against each other.
	always #(LF_HALF_NS) low_frequency_clock = ~low_frequency_clock;

	// Cycles between falling edges and cycles spent low.
	always @(posedge core_clk) begin
		prev_r <= buzzer_pulse_pin_n;
		run_r <= run_r + 1;
		low_r <= buzzer_pulse_pin_n ? 0 : low_r + 1;
		if (prev_r === 1'b1 && buzzer_pulse_pin_n === 1'b0) begin
			period <= run_r;
			run_r <= 1;
			fall_cnt <= fall_cnt + 1;
		end
		if (prev_r === 1'b0 && buzzer_pulse_pin_n === 1'b1) begin
			low_len <= low_r;
		end
	end
endmodule

/* sim/divider_square_wave_output_bench.sv */
// Purpose: Self-checking bench for the divider square-wave output.
// Assumes: Register access over AXI4-Lite; core_clk at 10 MHz.
// Notes:   Periods are timed by the load model in core cycles.
`timescale 1ns/1ps
`include "dvo_defines.vh"
`define CHECK(nm, ex, got) begin comparisons++; if ((got) !== (ex)) begin mismatches++; \
	$display("MISMATCH %s expected %0h seen %0h", nm, ex, got); end end
module divider_square_wave_output_bench;
	logic core_clk = 1'b0, srst = 1'b1, low_frequency_clock;
	logic [`MODE_W-1:0] power_mode = `MODE_NORMAL;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, pin_n;
	logic [1:0] s_axi_bresp, s_axi_rresp, resp;
	int mismatches = 0, comparisons = 0, fall_cnt, period, low_len, f, ex;

	always #50 core_clk = ~core_clk;

	divider_square_wave_output dut (.core_clk(core_clk), .srst(srst),
		.low_frequency_clock(low_frequency_clock), .power_mode(power_mode),
		.buzzer_pulse_pin_n(pin_n), .s_axi_awvalid(s_axi_awvalid),
		.s_axi_awready(s_axi_awready), .s_axi_awaddr(s_axi_awaddr), .s_axi_awprot(3'h0),
		.s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_wdata(s_axi_wdata),
		.s_axi_wstrb(4'hF), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
		.s_axi_bresp(s_axi_bresp), .s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready), .s_axi_araddr(s_axi_araddr), .s_axi_arprot(3'h0),
		.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
		.s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp));

	buzzer_load load (.core_clk(core_clk), .buzzer_pulse_pin_n(pin_n),
		.low_frequency_clock(low_frequency_clock), .fall_cnt(fall_cnt),
		.period(period), .low_len(low_len));

	// One write; each channel is released at the edge that takes it.
	// With hold set, bready is raised only once bvalid is seen, so the
	// response must stand through one stalled edge.
	task automatic axi_write(input logic [7:0] a, input logic [31:0] d,
		input bit hold = 1'b0);
		logic aw_done, w_done;
		@(posedge core_clk);
		s_axi_awvalid <= 1'b1;
		s_axi_awaddr <= a;
		s_axi_wvalid <= 1'b1;
		s_axi_wdata <= d;
		s_axi_bready <= !hold;
		aw_done = 1'b0;
		w_done = 1'b0;
		while (!(aw_done && w_done)) begin
			@(posedge core_clk);
			if (s_axi_awvalid && s_axi_awready) begin
				aw_done = 1'b1;
				s_axi_awvalid <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_done = 1'b1;
				s_axi_wvalid <= 1'b0;
			end
		end
		if (hold) begin
			do @(posedge core_clk); while (s_axi_bvalid !== 1'b1);
			s_axi_bready <= 1'b1;
		end
		do @(posedge core_clk); while (s_axi_bvalid !== 1'b1);
		resp = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask

	// One read; the data is taken at the edge where rvalid is seen.
	// With hold set, rready waits for rvalid, so the data must stand.
	task automatic axi_read(input logic [7:0] a, input bit hold = 1'b0);
		@(posedge core_clk);
		s_axi_arvalid <= 1'b1;
		s_axi_araddr <= a;
		s_axi_rready <= !hold;
		do @(posedge core_clk); while (s_axi_arready !== 1'b1);
		s_axi_arvalid <= 1'b0;
		if (hold) begin
			do @(posedge core_clk); while (s_axi_rvalid !== 1'b1);
			s_axi_rready <= 1'b1;
		end
		do @(posedge core_clk); while (s_axi_rvalid !== 1'b1);
		rd = s_axi_rdata;
		resp = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask

	task automatic wait_falls(input int n);
		int t;
		t = fall_cnt + n;
		while (fall_cnt < t) @(posedge core_clk);
	endtask

	task automatic complete_run;
		$display("comparisons %0d mismatches %0d", comparisons, mismatches);
		if (mismatches == 0 && comparisons > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	// Hang guard sized well above the slowest sequence of periods.
	initial begin
		#(80000 * 100);
		mismatches++;
		complete_run();
	end

	initial begin
		repeat (20) @(posedge core_clk);
		srst <= 1'b0;
		@(posedge core_clk);
		`CHECK("idle pin", 1'b1, pin_n)
		axi_read(`DIV_OUT_CTRL_ADDR);
		`CHECK("ctrl reset", 32'h0, rd)
		axi_write(`DIV_OUT_CTRL_ADDR, 32'hFF);
		axi_read(`DIV_OUT_CTRL_ADDR);
		`CHECK("ctrl readback", 32'h7, rd)
		for (int c = 0; c < 4; c++) begin
			axi_write(`DIV_OUT_CTRL_ADDR, 32'h4 | c);
			wait_falls(3);
			`CHECK("gear period", 4096 >> c, period)
			`CHECK("low phase", 2048 >> c, low_len)
		end
		axi_write(`DIV_OUT_CTRL_ADDR, 32'h3);
		repeat (3) @(posedge core_clk);
		f = fall_cnt;
		repeat (1000) @(posedge core_clk);
		`CHECK("falls when off", f, fall_cnt)
		`CHECK("pin off", 1'b1, pin_n)
		axi_write(`SRC_CTRL_ADDR, 32'h1);
		for (int c = 0; c < 4; c++) begin
			if (c == 3) begin
				power_mode <= `MODE_SLOW;
				axi_write(`SRC_CTRL_ADDR, 32'h0);
			end
			axi_write(`DIV_OUT_CTRL_ADDR, 32'h4 | (c % 3));
			wait_falls(3);
			ex = 2 * 613 * (32 >> (c % 3)) / 100;
			`CHECK("slow period", 1'b1, period >= ex - 2 && period <= ex + 2)
		end
		power_mode <= `MODE_LIGHT_SLEEP;
		axi_write(`DIV_OUT_CTRL_ADDR, 32'h7);
		repeat (3) @(posedge core_clk);
		f = fall_cnt;
		repeat (1000) @(posedge core_clk);
		`CHECK("reserved code", f, fall_cnt)
		for (int m = 4; m < 7; m++) begin
			power_mode <= (m == 5) ? `MODE_IDLE : `MODE_NORMAL;
			axi_write(`DIV_OUT_CTRL_ADDR, 32'h7);
			wait_falls(1);
			power_mode <= m[2:0];
			repeat (2) @(posedge core_clk);
			`CHECK("deep pin", 1'b1, pin_n)
			axi_read(`DIV_OUT_CTRL_ADDR);
			`CHECK("deep ctrl", 32'h3, rd)
		end
		power_mode <= `MODE_NORMAL;
		axi_write(8'h40, 32'h5, 1'b1);
		`CHECK("bad write resp", `RESP_SLVERR, resp)
		axi_read(8'h40, 1'b1);
		`CHECK("bad read resp", `RESP_SLVERR, resp)
		`CHECK("bad read data", 32'h0, rd)
		complete_run();
	end
endmodule
